// >>> rtl/clock_source_select_startup.sv
// Purpose: clock source select, start-up delays, prescaler, clock out
// Assumes: fuses static; sleep_req and wake_req from sys_clk logic
// Notes:
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module clock_source_select_startup #(
  parameter int SHORT_TICKS = clock_ctl_pkg::SHORT_WDT_TICKS,
  parameter int LONG_TICKS = clock_ctl_pkg::LONG_WDT_TICKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // fuses and factory calibration
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic divide_by_eight_fuse,
  input wire logic clock_out_fuse,
  input wire logic [7:0] factory_cal_value,
  // pins
  input wire logic external_clock_pin,
  input wire logic timer_osc_pin_one,
  // core side
  input wire logic sleep_req,
  input wire logic wake_req,
  output logic core_clk_en,
  output logic core_reset_hold,
  output logic clock_out_pin,
  output logic clock_out_oe,
  output logic timer_osc_enable,
  output logic timer_osc_ext_mode,
  output logic timer_osc_tick,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [clock_ctl_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [clock_ctl_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  localparam int CW = clock_ctl_pkg::CNT_W;
  localparam int AW = clock_ctl_pkg::ADDR_W;
  localparam int XW = clock_ctl_pkg::ACC_W;

  // refuse delays the counter cannot hold
  if (SHORT_TICKS < 1 || LONG_TICKS < 1 || LONG_TICKS >= (1 << CW) ||
      SHORT_TICKS >= (1 << CW)) begin : g_bad_ticks
    $error("start-up delay ticks out of counter range");
  end

  typedef enum logic [2:0] {
    ST_HOLD, ST_BASE, ST_EXTRA, ST_RUN, ST_SLEEP, ST_WAKE
  } state_t;

  // pins through two flops
  logic ext_lvl, ext_rise, tosc_lvl, tosc_rise;
  bit_sync u_ext_sync (
    .sys_clk(sys_clk), .din(external_clock_pin),
    .dout(ext_lvl), .rise(ext_rise)
  );
  bit_sync u_tosc_sync (
    .sys_clk(sys_clk), .din(timer_osc_pin_one),
    .dout(tosc_lvl), .rise(tosc_rise)
  );

  // oscillators run free; cleared once at the start of reset
  // two-state so the very first reset cycle after power-up clears phases
  bit reset_q_reg;
  logic osc_clear;
  logic rc_tick, low_tick, wdt_tick;
  logic [7:0] trim_reg, trim_next;
  logic [XW-1:0] rc_inc;
  assign osc_clear = reset & ~reset_q_reg;
  assign rc_inc = clock_ctl_pkg::trim_to_inc(trim_reg);
  tick_source #(.ACC_W(XW)) u_rc_osc (
    .sys_clk(sys_clk), .clear(osc_clear), .inc(rc_inc), .tick(rc_tick)
  );
  tick_source #(.ACC_W(XW)) u_low_osc (
    .sys_clk(sys_clk), .clear(osc_clear),
    .inc(clock_ctl_pkg::LOW_INC), .tick(low_tick)
  );
  // separate watchdog oscillator times both the short and long extra reset delays
  tick_source #(.ACC_W(XW)) u_wdt_osc (
    .sys_clk(sys_clk), .clear(osc_clear),
    .inc(clock_ctl_pkg::WDT_INC), .tick(wdt_tick)
  );

  // ---------------- register bus ----------------
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [AW-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic w_lane0_reg, w_lane0_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next, rd_word;
  logic wr_fire, rd_hit, wr_hit;
  logic [1:0] async_reg, async_next;
  logic [3:0] pre_sel_reg, pre_sel_next;

  // write completes once both address and data are held
  assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign wr_hit = aw_addr_reg == clock_ctl_pkg::STATUS_ADDR ||
                  aw_addr_reg == clock_ctl_pkg::ASYNC_ADDR ||
                  aw_addr_reg == clock_ctl_pkg::PRESCALE_ADDR ||
                  aw_addr_reg == clock_ctl_pkg::TRIM_ADDR;

  // read mux; unmapped words read zero with an error response
  logic [15:0] status_word;
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (araddr)
      clock_ctl_pkg::STATUS_ADDR: rd_word = {16'h0000, status_word};
      clock_ctl_pkg::ASYNC_ADDR: rd_word = {30'h0, async_reg};
      clock_ctl_pkg::PRESCALE_ADDR: rd_word = {28'h0, pre_sel_reg};
      clock_ctl_pkg::TRIM_ADDR: rd_word = {24'h0, trim_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // handshake state; one write and one read in flight
  always_comb begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_lane0_next = w_lane0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (awvalid && awready) begin
      aw_have_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_have_next = 1'b1;
      w_data_next = wdata;
      w_lane0_next = wstrb[0];
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? clock_ctl_pkg::RESP_OKAY
                          : clock_ctl_pkg::RESP_SLVERR;
    end else if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word;
      rresp_next = rd_hit ? clock_ctl_pkg::RESP_OKAY
                          : clock_ctl_pkg::RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (reset) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b0;
      rvalid_next = 1'b0;
      bresp_next = clock_ctl_pkg::RESP_OKAY;
      rresp_next = clock_ctl_pkg::RESP_OKAY;
      rdata_next = '0;
      aw_addr_next = '0;
      w_data_next = '0;
      w_lane0_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    aw_have_reg <= aw_have_next;
    aw_addr_reg <= aw_addr_next;
    w_have_reg <= w_have_next;
    w_data_reg <= w_data_next;
    w_lane0_reg <= w_lane0_next;
    bvalid_reg <= bvalid_next;
    bresp_reg <= bresp_next;
    rvalid_reg <= rvalid_next;
    rresp_reg <= rresp_next;
    rdata_reg <= rdata_next;
    awready <= ~aw_have_next;
    wready <= ~w_have_next;
    arready <= ~rvalid_next;
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  // ---------------- clock control core ----------------
  state_t st_reg, st_next;
  logic [CW-1:0] cnt_reg, cnt_next, extra_ticks;
  logic [3:0] src_reg, src_next;
  logic [1:0] sut_reg, sut_next;
  logic div8_reg, div8_next, clock_out_fuse_reg, clock_out_fuse_next;
  logic [8:0] pre_cnt_reg, pre_cnt_next;
  logic pre_tick_reg, pre_tick_next, src_tick, wr_ok;
  logic clk_en_next, hold_next, cko_next, tosc_en_next, ttick_next;

  assign wr_ok = wr_fire & w_lane0_reg;

  // source tick picked by the captured select code
  always_comb begin
    case (src_reg)
      clock_ctl_pkg::SRC_EXT: src_tick = ext_rise;
      clock_ctl_pkg::SRC_LOW: src_tick = low_tick;
      default: src_tick = rc_tick;
    endcase
  end

  // extra reset delay; reserved code adds none
  always_comb begin
    case (sut_reg)
      clock_ctl_pkg::SUT_SHORT: extra_ticks = CW'(SHORT_TICKS);
      clock_ctl_pkg::SUT_LONG: extra_ticks = CW'(LONG_TICKS);
      default: extra_ticks = '0;
    endcase
  end

  // start-up sequence, prescaler, trim and pin outputs
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    src_next = src_reg;
    sut_next = sut_reg;
    div8_next = div8_reg;
    clock_out_fuse_next = clock_out_fuse_reg;
    trim_next = trim_reg;
    async_next = async_reg;
    pre_sel_next = pre_sel_reg;
    pre_cnt_next = pre_cnt_reg;
    pre_tick_next = 1'b0;
    // prescaler keeps counting source ticks, also in reset
    if (osc_clear) begin
      pre_cnt_next = '0;
    end else if (src_tick) begin
      if (pre_cnt_reg >= clock_ctl_pkg::div_mask(pre_sel_reg)) begin
        pre_cnt_next = '0;
        pre_tick_next = 1'b1;
      end else begin
        pre_cnt_next = pre_cnt_reg + 9'h001;
      end
    end
    case (st_reg)
      ST_HOLD: begin
        st_next = ST_BASE;
        cnt_next = '0;
      end
      ST_BASE: if (src_tick) begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_next == clock_ctl_pkg::BASE_RESET_CK) begin
          cnt_next = '0;
          st_next = (extra_ticks == '0) ? ST_RUN : ST_EXTRA;
        end
      end
      ST_EXTRA: if (wdt_tick) begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_next == extra_ticks) begin
          st_next = ST_RUN;
        end
      end
      ST_RUN: if (sleep_req) begin
        st_next = ST_SLEEP;
      end
      ST_SLEEP: if (wake_req) begin
        st_next = ST_WAKE;
        cnt_next = '0;
      end
      ST_WAKE: if (src_tick) begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_next == clock_ctl_pkg::WAKE_CK) begin
          st_next = ST_RUN;
        end
      end
      default: st_next = ST_HOLD;
    endcase
    // software writes; reserved prescaler codes are ignored
    if (wr_ok) begin
      case (aw_addr_reg)
        clock_ctl_pkg::TRIM_ADDR: trim_next = w_data_reg[7:0];
        clock_ctl_pkg::ASYNC_ADDR: async_next = w_data_reg[1:0];
        clock_ctl_pkg::PRESCALE_ADDR:
          if (w_data_reg[3:0] <= clock_ctl_pkg::PRE_MAX) begin
            pre_sel_next = w_data_reg[3:0];
            pre_cnt_next = '0;
          end
        default: ;
      endcase
    end
    // fuses sampled through reset; trim and prescaler take defaults
    if (reset) begin
      st_next = ST_HOLD;
      cnt_next = '0;
      src_next = clock_source_select_fuses;
      sut_next = startup_time_fuses;
      div8_next = divide_by_eight_fuse;
      clock_out_fuse_next = clock_out_fuse;
      trim_next = factory_cal_value;
      async_next = '0;
      pre_sel_next = divide_by_eight_fuse ? clock_ctl_pkg::PRE_DIV8
                                          : clock_ctl_pkg::PRE_DIV1;
    end
    // registered pin and core outputs
    clk_en_next = pre_tick_next && st_next == ST_RUN;
    hold_next = reset || st_next == ST_HOLD || st_next == ST_BASE ||
                st_next == ST_EXTRA;
    // pin starts low on the clearing cycle, then toggles per divided tick
    cko_next = clock_out_fuse_next & ~osc_clear &
               (clock_out_pin ^ pre_tick_next);
    tosc_en_next = async_next[clock_ctl_pkg::ASYNC_TOSC_BIT] &&
                   src_next == clock_ctl_pkg::SRC_RC;
    ttick_next = tosc_en_next & tosc_rise &
                 async_next[clock_ctl_pkg::ASYNC_EXT_BIT];
  end

  always_ff @(posedge sys_clk) begin
    reset_q_reg <= reset;
    st_reg <= st_next;
    cnt_reg <= cnt_next;
    src_reg <= src_next;
    sut_reg <= sut_next;
    div8_reg <= div8_next;
    clock_out_fuse_reg <= clock_out_fuse_next;
    trim_reg <= trim_next;
    async_reg <= async_next;
    pre_sel_reg <= pre_sel_next;
    pre_cnt_reg <= pre_cnt_next;
    pre_tick_reg <= pre_tick_next;
    core_clk_en <= clk_en_next;
    core_reset_hold <= hold_next;
    clock_out_pin <= cko_next;
    clock_out_oe <= clock_out_fuse_next;
    timer_osc_enable <= tosc_en_next;
    timer_osc_ext_mode <= async_next[clock_ctl_pkg::ASYNC_EXT_BIT];
    timer_osc_tick <= ttick_next;
  end

  // status word; level of the synced pins is shown for debug
  assign status_word = {1'b0, clock_out_fuse_reg, div8_reg, sut_reg, src_reg,
    tosc_lvl, ext_lvl, src_reg != clock_ctl_pkg::SRC_RC &&
    src_reg != clock_ctl_pkg::SRC_LOW && src_reg != clock_ctl_pkg::SRC_EXT,
    sut_reg == clock_ctl_pkg::SUT_RSVD, timer_osc_enable,
    st_reg == ST_SLEEP, core_reset_hold};

  // ---------------- checks ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_wake_begin;
    st_reg == ST_SLEEP ##1 st_reg == ST_WAKE;
  endsequence

  a_trim_reset_load: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    reset |=> trim_reg == $past(factory_cal_value))
    else $error("trim not loaded from factory value in reset");
  a_trim_sets_rate: assert property (
    wr_ok && aw_addr_reg == clock_ctl_pkg::TRIM_ADDR |=>
    rc_inc == clock_ctl_pkg::trim_to_inc($past(w_data_reg[7:0])))
    else $error("trim write did not steer rc rate");
  a_prescale_reset: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    reset ##1 !reset |-> pre_sel_reg == (div8_reg ?
      clock_ctl_pkg::PRE_DIV8 : clock_ctl_pkg::PRE_DIV1))
    else $error("prescaler reset value wrong");
  a_divide_span: assert property (
    pre_tick_reg |-> $past(pre_cnt_reg) ==
      clock_ctl_pkg::div_mask($past(pre_sel_reg)))
    else $error("prescaler divided by wrong factor");
  a_clkout_reset: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    reset && clock_out_fuse_reg && pre_tick_reg |->
    clock_out_oe && $changed(clock_out_pin))
    else $error("clock out not driven in reset");
  a_clkout_edges: assert property (
    clock_out_oe && $changed(clock_out_pin) && $past(clock_out_oe) |->
    pre_tick_reg)
    else $error("clock out pin moved off a divided tick");
  a_tosc_only_rc: assert property (
    timer_osc_enable |-> src_reg == clock_ctl_pkg::SRC_RC)
    else $error("timer oscillator enabled off rc source");
  a_wake_quiet: assert property (
    s_wake_begin |-> !core_clk_en [*2])
    else $error("core clocked before wake count");
  a_base_count: assert property (
    $rose(st_reg == ST_EXTRA) |-> $past(cnt_reg) ==
      clock_ctl_pkg::BASE_RESET_CK - 16'h0001 && core_reset_hold)
    else $error("base reset count wrong");
endmodule : clock_source_select_startup

// >>> rtl/clock_ctl_pkg.sv
// Purpose: shared constants for the clock source and start-up block
// Assumes: 100 MHz sys_clk, oscillators modelled as tick enables
// Notes: fuse inputs read 1 for a programmed fuse
package clock_ctl_pkg;
  // clock rates in kHz
  localparam longint unsigned SYS_KHZ = 100000;
  localparam longint unsigned RC_KHZ = 8000;
  localparam longint unsigned LOW_KHZ = 128;
  localparam longint unsigned WDT_KHZ = 128;
  // phase accumulators turn a rate into tick enables
  localparam int ACC_W = 24;
  localparam logic [ACC_W-1:0] RC_INC = ACC_W'((RC_KHZ << ACC_W) / SYS_KHZ);
  localparam logic [ACC_W-1:0] LOW_INC = ACC_W'((LOW_KHZ << ACC_W) / SYS_KHZ);
  localparam logic [ACC_W-1:0] WDT_INC = ACC_W'((WDT_KHZ << ACC_W) / SYS_KHZ);
  // clock source select codes
  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_RC = 4'h2;
  localparam logic [3:0] SRC_LOW = 4'h3;
  // start-up time codes
  localparam logic [1:0] SUT_NONE = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;
  localparam logic [1:0] SUT_RSVD = 2'h3;
  // start-up counts in source cycles and extra delays in microseconds
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] BASE_RESET_CK = 16'h000e;
  localparam logic [CNT_W-1:0] WAKE_CK = 16'h0006;
  localparam longint unsigned DLY_SHORT_US = 4000;
  localparam longint unsigned DLY_LONG_US = 65000;
  localparam int SHORT_WDT_TICKS = int'(DLY_SHORT_US * WDT_KHZ / 1000);
  localparam int LONG_WDT_TICKS = int'(DLY_LONG_US * WDT_KHZ / 1000);
  // prescaler select values
  localparam logic [3:0] PRE_DIV1 = 4'h0;
  localparam logic [3:0] PRE_DIV8 = 4'h3;
  localparam logic [3:0] PRE_MAX = 4'h8;
  // trim: mid code and step as a shift of the nominal increment
  localparam logic [7:0] TRIM_MID = 8'h80;
  localparam int TRIM_SHIFT = 9;
  // register map; printed indices times four give byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] ASYNC_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] PRESCALE_INDEX = 12'h061;
  localparam logic [ADDR_W-1:0] TRIM_INDEX = 12'h066;
  localparam logic [ADDR_W-1:0] PRESCALE_ADDR = PRESCALE_INDEX << 2;
  localparam logic [ADDR_W-1:0] TRIM_ADDR = TRIM_INDEX << 2;
  localparam int ASYNC_EXT_BIT = 0;
  localparam int ASYNC_TOSC_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // trim code to accumulator increment, linear about the mid code
  function automatic logic [ACC_W-1:0] trim_to_inc(input logic [7:0] trim);
    logic [ACC_W-1:0] step;
    step = RC_INC >> TRIM_SHIFT;
    if (trim >= TRIM_MID)
      return RC_INC + ACC_W'(ACC_W'(trim - TRIM_MID) * step);
    else
      return RC_INC - ACC_W'(ACC_W'(TRIM_MID - trim) * step);
  endfunction : trim_to_inc

  // prescaler select to divisor minus one
  function automatic logic [8:0] div_mask(input logic [3:0] sel);
    return (9'h001 << sel) - 9'h001;
  endfunction : div_mask
endpackage : clock_ctl_pkg

// >>> rtl/tick_source.sv
// Purpose: phase-accumulator oscillator model giving one-cycle ticks
// Assumes: inc below half of the accumulator range
// Notes: clear restarts the phase; otherwise it runs free
`timescale 1ns/1ps
module tick_source #(
  parameter int ACC_W = 24
) (
  // clock and clear
  input wire logic sys_clk,
  input wire logic clear,
  // rate and output
  input wire logic [ACC_W-1:0] inc,
  output logic tick
);
  logic [ACC_W-1:0] acc_reg, acc_next;
  logic tick_reg, tick_next;

  // carry out of the accumulator is the tick
  always_comb begin
    {tick_next, acc_next} = {1'b0, acc_reg} + {1'b0, inc};
    if (clear) begin
      tick_next = 1'b0;
      acc_next = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    acc_reg <= acc_next;
    tick_reg <= tick_next;
  end

  assign tick = tick_reg;
endmodule : tick_source

// >>> rtl/bit_sync.sv
// Purpose: two-flop synchroniser with registered rising-edge pulse
// Assumes: input asynchronous to sys_clk; chain settles in three cycles
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module bit_sync (
  // clock
  input wire logic sys_clk,
  // pin and results
  input wire logic din,
  output logic dout,
  output logic rise
);
  logic [2:0] q_reg, q_next;
  logic rise_reg, rise_next;

  // shift chain; edge seen between second and third flop
  // no reset: edges keep coming through reset for the clock out pin,
  // and a pin already high at release gives no false edge
  always_comb begin
    q_next = {q_reg[1:0], din};
    rise_next = q_reg[1] & ~q_reg[2];
  end

  always_ff @(posedge sys_clk) begin
    q_reg <= q_next;
    rise_reg <= rise_next;
  end

  assign dout = q_reg[1];
  assign rise = rise_reg;
endmodule : bit_sync

// >>> sim/ext_clock_source.sv
// Purpose: external clock driver model for the external clock pin
// Assumes: fixed rate, offset so edges never meet the bench clock
// Notes: pin rests low while run is low
`timescale 1ns/1ps
module ext_clock_source #(
  parameter realtime HALF_NS = 50.0
) (
  // control and pin
  input wire logic run,
  output logic clk_out
);
  // constant period well under 20 MHz, no cycle-to-cycle drift
  initial begin
    clk_out = 1'b0;
    #3;
    forever begin
      #(HALF_NS) clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule : ext_clock_source

// >>> sim/clock_source_select_startup_bench.sv
// Purpose: bench for clock source select, start-up and clock out
// Assumes: external pin at 10 MHz, watchdog extra delays shrunk to 2, 3
// Notes: bus tasks sample ready at the falling edge, act at the rising
`timescale 1ns/1ps
module clock_source_select_startup_bench;
  logic sys_clk, reset, divide_by_eight_fuse, clock_out_fuse;
  logic [3:0] clock_source_select_fuses, wstrb;
  logic [1:0] startup_time_fuses, bresp, rresp, rs;
  logic [7:0] factory_cal_value;
  logic external_clock_pin, timer_osc_pin_one, sleep_req, wake_req;
  logic core_clk_en, core_reset_hold, clock_out_pin, clock_out_oe;
  logic timer_osc_enable, timer_osc_ext_mode, timer_osc_tick;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [clock_ctl_pkg::ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  int errors, comparisons, n, k, g;

  ext_clock_source i_ext_clock_source (.run(1'b1),
    .clk_out(external_clock_pin));
  clock_source_select_startup #(.SHORT_TICKS(2), .LONG_TICKS(3))
    i_clock_source_select_startup (.sys_clk, .reset,
    .clock_source_select_fuses, .startup_time_fuses, .divide_by_eight_fuse,
    .clock_out_fuse, .factory_cal_value, .external_clock_pin,
    .timer_osc_pin_one, .sleep_req, .wake_req, .core_clk_en,
    .core_reset_hold, .clock_out_pin, .clock_out_oe, .timer_osc_enable,
    .timer_osc_ext_mode, .timer_osc_tick, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic hung;
    errors++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    summarize();
  endtask : hung

  // one write or one read; payload held until its own ready
  task automatic bus(input bit wr, input logic [11:0] a,
      input logic [31:0] d);
    logic ra, rw, rb;
    @(posedge sys_clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    for (n = 0; n < 100; n++) begin
      @(negedge sys_clk);
      ra = wr ? awready : arready;
      rw = wready;
      rb = wr ? bvalid : rvalid;
      rs = wr ? bresp : rresp;
      rd = rdata;
      @(posedge sys_clk);
      if (ra) awvalid <= 1'b0;
      if (ra) arvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
      if (rb) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (n == 100) hung();
  endtask : bus

  // reset with given fuses; k counts clock out edges, n the hold length
  task automatic do_reset(input logic [3:0] s, input logic [1:0] t,
      input logic d8, input logic co, input int len);
    logic p;
    @(posedge sys_clk);
    reset <= 1'b1;
    clock_source_select_fuses <= s;
    startup_time_fuses <= t;
    divide_by_eight_fuse <= d8;
    clock_out_fuse <= co;
    k = 0;
    p = clock_out_pin;
    repeat (len) begin
      @(negedge sys_clk);
      k += int'(clock_out_pin !== p);
      p = clock_out_pin;
    end
    @(posedge sys_clk);
    reset <= 1'b0;
    for (n = 0; n < 20000 && core_reset_hold !== 1'b0; n++)
      @(negedge sys_clk);
    if (n == 20000) hung();
  endtask : do_reset

  // cycles between two core ticks, or two clock out edges
  task automatic gap(input bit pin);
    logic p, e;
    int c;
    p = clock_out_pin;
    c = 0;
    g = 0;
    for (n = 0; n < 4000 && c < 2; n++) begin
      @(negedge sys_clk);
      e = pin ? (clock_out_pin !== p) : (core_clk_en === 1'b1);
      p = clock_out_pin;
      if (c == 1) g++;
      if (e) c++;
    end
    if (c < 2) hung();
  endtask : gap

  // main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {sleep_req, wake_req, timer_osc_pin_one} = 3'h0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    factory_cal_value = clock_ctl_pkg::TRIM_MID;
    clock_source_select_fuses = clock_ctl_pkg::SRC_EXT;
    startup_time_fuses = clock_ctl_pkg::SUT_NONE;
    {divide_by_eight_fuse, clock_out_fuse} = 2'h3;
    do_reset(clock_ctl_pkg::SRC_EXT, clock_ctl_pkg::SUT_NONE, 1, 1, 8);
    check(32'(n >= 140 && n <= 165), 1);
    bus(0, clock_ctl_pkg::PRESCALE_ADDR, 0);
    check(rd, clock_ctl_pkg::PRE_DIV8);
    bus(0, clock_ctl_pkg::TRIM_ADDR, 0);
    check(rd, clock_ctl_pkg::TRIM_MID);
    bus(1, clock_ctl_pkg::TRIM_ADDR, 32'h5a);
    check(rs, clock_ctl_pkg::RESP_OKAY);
    bus(0, clock_ctl_pkg::TRIM_ADDR, 0);
    check(rd, 32'h5a);
    bus(0, 12'h010, 0);
    check(rs, clock_ctl_pkg::RESP_SLVERR);
    gap(0);
    check(g, 80);
    gap(1);
    check(g, 80);
    bus(1, clock_ctl_pkg::ASYNC_ADDR, 3);
    check(timer_osc_enable, 0);
    bus(1, clock_ctl_pkg::PRESCALE_ADDR, 0);
    gap(0);
    check(g, 10);
    $display("external source test done");
    @(posedge sys_clk) sleep_req <= 1'b1;
    @(posedge sys_clk) sleep_req <= 1'b0;
    k = 0;
    repeat (30) @(negedge sys_clk) k += core_clk_en;
    check(k, 0);
    @(posedge sys_clk) wake_req <= 1'b1;
    @(posedge sys_clk) wake_req <= 1'b0;
    for (n = 0; n < 500 && core_clk_en !== 1'b1; n++) @(negedge sys_clk);
    check(32'(n >= 50 && n <= 80), 1);
    $display("wake test done");
    do_reset(clock_ctl_pkg::SRC_EXT, clock_ctl_pkg::SUT_NONE, 0, 1, 40);
    check(32'(k >= 3), 1);
    bus(0, clock_ctl_pkg::PRESCALE_ADDR, 0);
    check(rd, clock_ctl_pkg::PRE_DIV1);
    bus(0, clock_ctl_pkg::TRIM_ADDR, 0);
    check(rd, clock_ctl_pkg::TRIM_MID);
    $display("reset clock out test done");
    do_reset(clock_ctl_pkg::SRC_RC, clock_ctl_pkg::SUT_SHORT, 0, 0, 8);
    check(32'(n >= 1500 && n <= 2000), 1);
    check(clock_out_oe, 0);
    gap(0);
    check(32'(g >= 12 && g <= 13), 1);
    bus(1, clock_ctl_pkg::ASYNC_ADDR, 3);
    check({timer_osc_enable, timer_osc_ext_mode}, 2'h3);
    k = 0;
    // timer pin period of 64 cycles keeps it under a quarter of rc rate
    for (g = 0; g < 128; g++) begin
      @(posedge sys_clk) timer_osc_pin_one <= g[5];
      @(negedge sys_clk) k += timer_osc_tick;
    end
    check(k, 2);
    $display("rc source test done");
    do_reset(clock_ctl_pkg::SRC_LOW, clock_ctl_pkg::SUT_NONE, 0, 0, 8);
    check(32'(n >= 10000 && n <= 11500), 1);
    gap(0);
    check(32'(g >= 780 && g <= 782), 1);
    $display("low rate source test done");
    summarize();
  end
endmodule : clock_source_select_startup_bench
